// ===== rtl/nrc_cfg.svh
// Register offsets, field positions, reset values and limits of the neuron context block
`ifndef NRC_CFG_SVH
`define NRC_CFG_SVH

`define NRC_ADDR_W 4
`define NRC_OFS_GCTX 4'h0
`define NRC_OFS_MINIF 4'h1
`define NRC_OFS_MAXIF 4'h2
`define NRC_OFS_MODE 4'h3
`define NRC_OFS_CTRL 4'h4
`define NRC_OFS_PTR 4'h5
`define NRC_OFS_DATA 4'h6
`define NRC_OFS_COUNT 4'h7
`define NRC_OFS_COMMIT 4'h8
`define NRC_OFS_RSEL 4'h9
`define NRC_OFS_RCTX 4'hA
`define NRC_OFS_RAIF 4'hB
`define NRC_OFS_RMINIF 4'hC
`define NRC_OFS_RCAT 4'hD
`define NRC_OFS_RDEGEN 4'hE

`define NRC_CTX_MSB 6
`define NRC_NORM_BIT 7
`define NRC_NN_BIT 4
`define NRC_SR_BIT 0
`define NRC_DEGEN_BIT 15
`define NRC_CAT_MSB 14

`define NRC_GCTX_RST 8'h00
`define NRC_MAXIF_RST 16'h4000
`define NRC_MINIF_RST 16'h0002
`define NRC_IF_LOW 16'h0002
`define NRC_MAXIF_HIGH 16'hFFFE
`define NRC_COUNT_FULL 16'hFFFF

`endif

// ===== rtl/nrc_pkg.sv
// Types shared by the neuron context block and its bench
package nrc_pkg;

	typedef logic [15:0] nrc_word_t;

	// One register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		nrc_word_t wdata;
	} nrc_bus_req_t;

	// Restore record phase, one-hot
	typedef enum logic [4:0] {
		PH_CTX = 5'h01,
		PH_COMP = 5'h02,
		PH_AIF = 5'h04,
		PH_MINIF = 5'h08,
		PH_CAT = 5'h10
	} nrc_phase_t;

endpackage

// ===== rtl/nrc_top.sv
// Neuron chain context, influence limits, mode select and knowledge restore
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/100ps
`include "nrc_cfg.svh"

module nrc_top #(
	parameter int NEURONS = 8,
	parameter int NEURON_MEMORY_DEPTH = 4,
	parameter int COMP_W = 8
) (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire nrc_pkg::nrc_bus_req_t bus_req_i,
	output logic [15:0] rd_data_o,
	output logic [NEURONS-1:0] neuron_active_o,
	output logic [NEURONS-1:0] max_component_norm_o,
	output logic nearest_neighbour_mode_o,
	output logic restore_mode_o
);
	import nrc_pkg::*;

	// Index widths; pointer and count carry one extra bit, so a chain filled
	// to its last neuron reads as NEURONS instead of wrapping back to zero.
	// The component index only walks inside one record.
	localparam int IDX_W = (NEURONS > 1) ? $clog2(NEURONS) : 1;
	localparam int WIX_W = (NEURON_MEMORY_DEPTH > 1) ? $clog2(NEURONS * 0 + NEURON_MEMORY_DEPTH) : 1;
	localparam logic [IDX_W:0] NEURONS_CNT = (IDX_W + 1)'(NEURONS);
	localparam logic [WIX_W-1:0] WIX_LAST = WIX_W'(NEURON_MEMORY_DEPTH - 1);

	// Whole state of the block
	typedef struct packed {
		// Read data register and per-neuron response masks
		nrc_word_t rdata;
		logic [NEURONS-1:0] active;
		logic [NEURONS-1:0] norm_max;
		// Global settings, copied into a neuron only when it is committed
		logic [7:0] global_context_reg;
		nrc_word_t minif;
		nrc_word_t maxif;
		// Operating mode bits
		logic nn;
		logic sr;
		// Restore stream position, record phase and fill state
		logic [IDX_W:0] ptr;
		logic [WIX_W-1:0] wix;
		nrc_phase_t phase;
		logic [IDX_W:0] count;
		logic full;
		// Readback select
		logic [IDX_W-1:0] rsel;
		// Stored knowledge of each neuron: context, model, fields, category
		logic [NEURONS-1:0][7:0] neuron_context_reg;
		logic [NEURONS-1:0][NEURON_MEMORY_DEPTH-1:0][COMP_W-1:0] comp;
		logic [NEURONS-1:0][15:0] aif;
		logic [NEURONS-1:0][15:0] nminif;
		logic [NEURONS-1:0][15:0] cat;
	} nrc_state_t;

	nrc_state_t st_r;
	nrc_state_t st_nxt;

	// Clamp a limit value into an inclusive range
	function automatic nrc_word_t clamp_if(input nrc_word_t v, input nrc_word_t lo,
		input nrc_word_t hi);
		nrc_word_t res;
		res = v;
		if (v < lo) begin
			res = lo;
		end else if (v > hi) begin
			res = hi;
		end
		return res;
	endfunction

	// Slot addressed by a pointer or count; the extra top bit is dropped
	function automatic logic [IDX_W-1:0] slot_of(input logic [IDX_W:0] p);
		return p[IDX_W-1:0];
	endfunction

	// A neuron responds when its context matches, or when the global one is zero
	function automatic logic ctx_match(input logic [7:0] ncx, input logic [7:0] gcx);
		logic hit;
		hit = (gcx[`NRC_CTX_MSB:0] == '0) ||
			(ncx[`NRC_CTX_MSB:0] == gcx[`NRC_CTX_MSB:0]);
		return hit;
	endfunction

	// Next-state logic: register port, restore stream, commit, response masks.
	// A read and a write in the same cycle are both taken; the read shows the
	// registered state from before that write. Nothing here ever stalls the
	// host: every request is finished at the edge that takes it.
	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata = '0;

		// Read data stand one cycle after the strobe; unmapped reads give zero
		if (bus_req_i.rd) begin
			case (bus_req_i.addr)
				// Global context reads back as held, unclamped
				`NRC_OFS_GCTX: begin
					st_nxt.rdata = nrc_word_t'(st_r.global_context_reg);
				end
				// Limits
				`NRC_OFS_MINIF: begin
					st_nxt.rdata = st_r.minif;
				end
				`NRC_OFS_MAXIF: begin
					st_nxt.rdata = st_r.maxif;
				end
				// Mode and control show only their defined bit, the rest reads zero
				`NRC_OFS_MODE: begin
					st_nxt.rdata[`NRC_NN_BIT] = st_r.nn;
				end
				`NRC_OFS_CTRL: begin
					st_nxt.rdata[`NRC_SR_BIT] = st_r.sr;
				end
				// Slot that the next restore record fills
				`NRC_OFS_PTR: begin
					st_nxt.rdata = nrc_word_t'(st_r.ptr);
				end
				// Filled neurons, or all ones once a restore record or a commit found no room
				`NRC_OFS_COUNT: begin
					if (st_r.full) begin
						st_nxt.rdata = `NRC_COUNT_FULL;
					end else begin
						st_nxt.rdata = nrc_word_t'(st_r.count);
					end
				end
				// Readback window onto the neuron picked by the select register
				`NRC_OFS_RSEL: begin
					st_nxt.rdata = nrc_word_t'(st_r.rsel);
				end
				`NRC_OFS_RCTX: begin
					st_nxt.rdata = nrc_word_t'(st_r.neuron_context_reg[st_r.rsel]);
				end
				`NRC_OFS_RAIF: begin
					st_nxt.rdata = st_r.aif[st_r.rsel];
				end
				`NRC_OFS_RMINIF: begin
					st_nxt.rdata = st_r.nminif[st_r.rsel];
				end
				`NRC_OFS_RCAT: begin
					// Effective category without the degenerated flag
					st_nxt.rdata = nrc_word_t'(st_r.cat[st_r.rsel][`NRC_CAT_MSB:0]);
				end
				// Degenerated flag alone, in bit zero
				`NRC_OFS_RDEGEN: begin
					st_nxt.rdata[0] = st_r.cat[st_r.rsel][`NRC_DEGEN_BIT];
				end
				default: begin
					st_nxt.rdata = '0;
				end
			endcase
		end

		// Register writes
		if (bus_req_i.wr) begin
			case (bus_req_i.addr)
				`NRC_OFS_GCTX: begin
					st_nxt.global_context_reg = bus_req_i.wdata[7:0];
				end
				// Limits are clamped into range rather than refused, so a bad
				// host value can never leave the minimum above the maximum
				`NRC_OFS_MINIF: begin
					st_nxt.minif = clamp_if(bus_req_i.wdata, `NRC_IF_LOW, st_r.maxif);
				end
				`NRC_OFS_MAXIF: begin
					st_nxt.maxif = clamp_if(bus_req_i.wdata, `NRC_IF_LOW, `NRC_MAXIF_HIGH);
					// Keep the minimum at or below a lowered maximum
					if (st_r.minif > st_nxt.maxif) begin
						st_nxt.minif = st_nxt.maxif;
					end
				end
				// Nearest-neighbour mode only blocks commits; stored neurons stay
				`NRC_OFS_MODE: begin
					st_nxt.nn = bus_req_i.wdata[`NRC_NN_BIT];
				end
				// Only the rising edge of the restore bit erases, so writing a one
				// again while loading keeps the records already streamed in
				`NRC_OFS_CTRL: begin
					st_nxt.sr = bus_req_i.wdata[`NRC_SR_BIT];
					// Entering restore wipes the chain and rewinds the pointer
					if (bus_req_i.wdata[`NRC_SR_BIT] && !st_r.sr) begin
						st_nxt.count = '0;
						st_nxt.full = 1'b0;
						st_nxt.ptr = '0;
						st_nxt.wix = '0;
						st_nxt.phase = PH_CTX;
						st_nxt.neuron_context_reg = '0;
						st_nxt.comp = '0;
						st_nxt.aif = '0;
						st_nxt.nminif = '0;
						st_nxt.cat = '0;
					end
				end
				`NRC_OFS_PTR: begin
					// Any write puts the pointer on the first neuron; outside
					// restore it is ignored so normal use cannot upset the stream
					if (st_r.sr) begin
						st_nxt.ptr = '0;
						st_nxt.wix = '0;
						st_nxt.phase = PH_CTX;
					end
				end
				// Restore stream: one write per word in fixed record order
				`NRC_OFS_DATA: begin
					if (st_r.sr) begin
						if (st_r.ptr >= NEURONS_CNT) begin
							// No neuron left for this record
							st_nxt.full = 1'b1;
						end else begin
							case (st_r.phase)
								// Context word opens a record
								PH_CTX: begin
									st_nxt.neuron_context_reg[st_r.ptr[IDX_W-1:0]] =
										bus_req_i.wdata[7:0];
									st_nxt.wix = '0;
									st_nxt.phase = PH_COMP;
								end
								// Components fill from index zero up
								PH_COMP: begin
									st_nxt.comp[st_r.ptr[IDX_W-1:0]][st_r.wix] =
										bus_req_i.wdata[COMP_W-1:0];
									if (st_r.wix == WIX_LAST) begin
										st_nxt.phase = PH_AIF;
									end else begin
										st_nxt.wix = st_r.wix + 1'b1;
									end
								end
								// Active then minimum influence field
								PH_AIF: begin
									st_nxt.aif[st_r.ptr[IDX_W-1:0]] = bus_req_i.wdata;
									st_nxt.phase = PH_MINIF;
								end
								PH_MINIF: begin
									st_nxt.nminif[st_r.ptr[IDX_W-1:0]] = bus_req_i.wdata;
									st_nxt.phase = PH_CAT;
								end
								// Category closes the record; count follows the pointer,
								// so a cut record is never counted
								PH_CAT: begin
									st_nxt.cat[st_r.ptr[IDX_W-1:0]] = bus_req_i.wdata;
									st_nxt.ptr = st_r.ptr + 1'b1;
									st_nxt.count = st_r.ptr + 1'b1;
									st_nxt.phase = PH_CTX;
								end
								default: begin
									st_nxt.phase = PH_CTX;
								end
							endcase
						end
					end
				end
				`NRC_OFS_COMMIT: begin
					// Learning commit takes the current global settings
					if (!st_r.nn && !st_r.sr) begin
						// A commit with no free neuron is dropped and flags the chain full
						if (st_r.count >= NEURONS_CNT) begin
							st_nxt.full = 1'b1;
						end else begin
							// Only the new slot is written; older neurons keep their fields
							st_nxt.neuron_context_reg[slot_of(st_r.count)] =
								st_r.global_context_reg;
							st_nxt.aif[slot_of(st_r.count)] = st_r.maxif;
							st_nxt.nminif[slot_of(st_r.count)] = st_r.minif;
							st_nxt.cat[slot_of(st_r.count)] = bus_req_i.wdata;
							st_nxt.count = st_r.count + 1'b1;
						end
					end
				end
				// Readback select keeps only the bits that address a neuron
				`NRC_OFS_RSEL: begin
					st_nxt.rsel = bus_req_i.wdata[IDX_W-1:0];
				end
				default: begin
					st_nxt.rsel = st_r.rsel;
				end
			endcase
		end

		// Response masks: context match and per-neuron norm select
		// Masks are registered, so they follow a change of state one cycle later;
		// only committed slots below the count may respond
		for (int i = 0; i < NEURONS; i++) begin
			st_nxt.active[i] = ((IDX_W + 1)'(i) < st_r.count) &&
				ctx_match(st_r.neuron_context_reg[i], st_r.global_context_reg);
			// Context bit seven set means max-component norm, 128 included
			st_nxt.norm_max[i] = st_r.neuron_context_reg[i][`NRC_NORM_BIT];
		end
	end

	// State register; radial-basis mode and default limits from reset.
	// Everything else starts cleared, phase at PH_CTX: no neuron committed, restore off.
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			st_r <= '0;
			st_r.global_context_reg <= `NRC_GCTX_RST;
			st_r.maxif <= `NRC_MAXIF_RST;
			st_r.minif <= `NRC_MINIF_RST;
			st_r.nn <= 1'b0;
			st_r.phase <= PH_CTX;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register; none of them is combinational,
	// so a host can sample them anywhere in the cycle
	assign rd_data_o = st_r.rdata;
	assign neuron_active_o = st_r.active;
	assign max_component_norm_o = st_r.norm_max;
	assign nearest_neighbour_mode_o = st_r.nn;
	assign restore_mode_o = st_r.sr;

endmodule

// ===== bench/nrc_host.sv
// Host model that drives the register port of the neuron context block
`timescale 1ns/100ps
module nrc_host #(
	parameter int DEPTH = 4
) (
	input wire logic ref_clk_i,
	input wire logic [15:0] rd_data_i,
	output nrc_pkg::nrc_bus_req_t bus_req_o
);
	import nrc_pkg::*;

	// Idle port at time zero
	initial bus_req_o = '0;

	// One write cycle; idle lines show the inverse of the last value
	task automatic wr(input logic [3:0] a, input nrc_word_t d);
		@(posedge ref_clk_i) bus_req_o <= '{1'b1, 1'b0, a, d};
		@(posedge ref_clk_i) bus_req_o <= '{1'b0, 1'b0, ~a, ~d};
	endtask

	// One read cycle, data taken in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output nrc_word_t d);
		@(posedge ref_clk_i) bus_req_o <= '{1'b0, 1'b1, a, 16'h0};
		@(posedge ref_clk_i) bus_req_o <= '{1'b0, 1'b0, ~a, 16'hFFFF};
		#1 d = rd_data_i;
	endtask

	// One neuron record in fixed order: context, components, aif, minif, category
	task automatic rec(input nrc_word_t c, m, f, n, k);
		wr(4'h6, c);
		for (int i = 0; i < DEPTH; i++) begin
			wr(4'h6, m + 16'(i));
		end
		wr(4'h6, f);
		wr(4'h6, n);
		wr(4'h6, k);
	endtask
endmodule

// ===== bench/nrc_properties.sv
// Port checker of the neuron context block
`timescale 1ns/100ps
`include "nrc_cfg.svh"
module nrc_properties #(
	parameter int NEURONS = 8
) (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire nrc_pkg::nrc_bus_req_t bus_req_i,
	input wire logic [15:0] rd_data_o,
	input wire logic [NEURONS-1:0] neuron_active_o,
	input wire logic [NEURONS-1:0] max_component_norm_o,
	input wire logic nearest_neighbour_mode_o,
	input wire logic restore_mode_o
);
	import nrc_pkg::*;

	// Decoded requests
	wire w_mode = bus_req_i.wr && bus_req_i.addr == `NRC_OFS_MODE;
	wire w_ctrl = bus_req_i.wr && bus_req_i.addr == `NRC_OFS_CTRL;
	wire w_cmt = bus_req_i.wr && bus_req_i.addr == `NRC_OFS_COMMIT;
	wire r_mode = bus_req_i.rd && bus_req_i.addr == `NRC_OFS_MODE;
	wire r_ctrl = bus_req_i.rd && bus_req_i.addr == `NRC_OFS_CTRL;
	wire r_cnt = bus_req_i.rd && bus_req_i.addr == `NRC_OFS_COUNT;

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	property p_nn_set;
		w_mode |=> nearest_neighbour_mode_o == $past(bus_req_i.wdata[`NRC_NN_BIT]);
	endproperty
	a_nn_set: assert property (p_nn_set) else $error("mode bit not taken");
	property p_nn_hold;
		!w_mode |=> $stable(nearest_neighbour_mode_o);
	endproperty
	a_nn_hold: assert property (p_nn_hold) else $error("mode bit moved");
	property p_sr_set;
		w_ctrl |=> restore_mode_o == $past(bus_req_i.wdata[`NRC_SR_BIT]);
	endproperty
	a_sr_set: assert property (p_sr_set) else $error("restore bit not taken");
	property p_erase;
		$rose(restore_mode_o) |=> neuron_active_o == '0;
	endproperty
	a_erase: assert property (p_erase) else $error("knowledge kept on restore");
	property p_mode_rd;
		r_mode |=> rd_data_o == {11'h0, nearest_neighbour_mode_o, 4'h0};
	endproperty
	a_mode_rd: assert property (p_mode_rd) else $error("mode read wrong");
	property p_ctrl_rd;
		r_ctrl |=> rd_data_o == {15'h0, restore_mode_o};
	endproperty
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl read wrong");
	property p_rd_idle;
		!bus_req_i.rd |=> rd_data_o == 16'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_nn_frozen;
		nearest_neighbour_mode_o && w_cmt && !$past(bus_req_i.wr)
			|=> ##1 neuron_active_o == $past(neuron_active_o);
	endproperty
	a_nn_frozen: assert property (p_nn_frozen) else $error("commit in nn mode");

	// Main scenarios
	c_restore: cover property ($rose(restore_mode_o));
	c_nn: cover property (nearest_neighbour_mode_o && w_cmt);
	c_full: cover property (r_cnt ##1 rd_data_o == `NRC_COUNT_FULL);
endmodule

bind nrc_top nrc_properties #(.NEURONS(NEURONS)) u_props (.ref_clk_i(ref_clk_i),
	.reset_i(reset_i), .bus_req_i(bus_req_i), .rd_data_o(rd_data_o),
	.neuron_active_o(neuron_active_o), .max_component_norm_o(max_component_norm_o),
	.nearest_neighbour_mode_o(nearest_neighbour_mode_o), .restore_mode_o(restore_mode_o));

// ===== bench/neuron_context_and_restore_bench.sv
// Self-checking bench of the neuron context and restore block
`timescale 1ns/100ps
module neuron_context_and_restore_bench;
	import nrc_pkg::*;
	localparam int N = 4;
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	nrc_bus_req_t req;
	logic [15:0] rdata;
	logic [N-1:0] act;
	logic [N-1:0] norm;
	logic nn;
	logic sr;
	int n_fail = 0;
	int n_checks = 0;
	nrc_word_t v;

	nrc_top #(.NEURONS(N)) u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
		.bus_req_i(req), .rd_data_o(rdata), .neuron_active_o(act),
		.max_component_norm_o(norm), .nearest_neighbour_mode_o(nn), .restore_mode_o(sr));
	nrc_host #(.DEPTH(4)) u_host (.ref_clk_i(ref_clk_i), .rd_data_i(rdata), .bus_req_o(req));

	// Compare and count
	task automatic chk(input nrc_word_t got, input nrc_word_t exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [3:0] a, input nrc_word_t exp);
		u_host.rd(a, v);
		chk(v, exp);
	endtask
	task automatic mchk(input nrc_word_t exp);
		repeat (2) @(posedge ref_clk_i);
		#1 chk(16'(act), exp);
	endtask

	task automatic t_reset;
		rchk(4'h0, 16'h0000);
		rchk(4'h2, 16'h4000);
		rchk(4'h1, 16'h0002);
		rchk(4'h3, 16'h0000);
		$display("test reset done");
	endtask
	task automatic t_limits;
		u_host.wr(4'h2, 16'hFFFF);
		rchk(4'h2, 16'hFFFE);
		u_host.wr(4'h1, 16'hFFFF);
		rchk(4'h1, 16'hFFFE);
		u_host.wr(4'h2, 16'h0010);
		rchk(4'h1, 16'h0010);
		u_host.wr(4'h1, 16'h0000);
		rchk(4'h1, 16'h0002);
		u_host.wr(4'h2, 16'h0000);
		rchk(4'h2, 16'h0002);
		u_host.wr(4'h2, 16'h0030);
		$display("test limits done");
	endtask
	task automatic t_commit;
		u_host.wr(4'h0, 16'h0085);
		u_host.wr(4'h8, 16'h0007);
		mchk(16'h0001);
		chk(16'(norm), 16'h0001);
		u_host.wr(4'h9, 16'h0000);
		rchk(4'hA, 16'h0085);
		rchk(4'hB, 16'h0030);
		u_host.wr(4'h0, 16'h0003);
		mchk(16'h0000);
		u_host.wr(4'h0, 16'h0000);
		mchk(16'h0001);
		rchk(4'hA, 16'h0085);
		u_host.wr(4'h0, 16'h0001);
		u_host.wr(4'h8, 16'h0009);
		mchk(16'h0002);
		chk(16'(norm), 16'h0001);
		$display("test commit done");
	endtask
	task automatic t_nn;
		u_host.wr(4'h3, 16'h0010);
		rchk(4'h3, 16'h0010);
		chk(16'(nn), 16'h0001);
		u_host.wr(4'h8, 16'h0005);
		rchk(4'h7, 16'h0002);
		u_host.wr(4'h3, 16'h0000);
		rchk(4'h3, 16'h0000);
		chk(16'(nn), 16'h0000);
		$display("test nn done");
	endtask
	task automatic t_restore;
		u_host.wr(4'h0, 16'h0000);
		u_host.wr(4'h4, 16'h0001);
		u_host.wr(4'h5, 16'h0000);
		mchk(16'h0000);
		chk(16'(sr), 16'h0001);
		rchk(4'h7, 16'h0000);
		for (int i = 0; i < N; i++) begin
			u_host.rec(16'h0002, 16'h0010, 16'h0020, 16'h0002, 16'h8001 + 16'(i));
			rchk(4'h7, 16'(i + 1));
		end
		mchk(16'h000F);
		u_host.wr(4'h9, 16'h0000);
		rchk(4'hA, 16'h0002);
		rchk(4'hB, 16'h0020);
		rchk(4'hC, 16'h0002);
		rchk(4'hD, 16'h0001);
		rchk(4'hE, 16'h0001);
		u_host.rec(16'h0002, 16'h0010, 16'h0020, 16'h0002, 16'h0009);
		rchk(4'h7, 16'hFFFF);
		u_host.wr(4'h4, 16'h0000);
		rchk(4'h4, 16'h0000);
		chk(16'(sr), 16'h0000);
		$display("test restore done");
	endtask

	// Verdict and end of run
	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Clock at 125 MHz
	initial begin
		forever #4 ref_clk_i = ~ref_clk_i;
	end

	// Reset, then the scenarios
	initial begin
		repeat (3) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		t_reset();
		t_limits();
		t_commit();
		t_nn();
		t_restore();
		report_and_stop();
	end

	// Watchdog well beyond the expected run
	initial begin
		#100000;
		n_fail++;
		report_and_stop();
	end
endmodule
